// >>> core/pix_pkg.sv
// Constants, register map and types for the pixel shift and black-level stage.
// Function
// - Shift each pixel left by the factor.
// - Saturate to all ones of active format.
// - Factor resets to zero, zero passes through.
// - Factor one shifts one bit, two shifts two.
// - Vacated low bits are filled with zero.
// - Narrow formats shift 12 bits, keep top bits.
// - Wait selector picks frame or burst trigger.
// - Wait flag true while waiting, false when busy.
// - Black level added uniformly to every pixel.
// - Limits switch widens accepted parameter ranges.
package pix_pkg;
  localparam int PIX_W = 12;
  localparam int SHIFT_W = 3;
  localparam int SHARP_W = 6;
  localparam logic [11:0] MAX_8 = 12'h0FF;
  localparam logic [11:0] MAX_10 = 12'h3FF;
  localparam logic [11:0] MAX_12 = 12'hFFF;
  localparam logic [2:0] SHIFT_MAX_LIM = 3'h4;
  localparam logic [2:0] SHIFT_MAX_WIDE = 3'h7;
  localparam logic [5:0] SHARP_MAX_LIM = 6'h03;
  localparam logic [5:0] SHARP_MAX_WIDE = 6'h3F;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SHIFT = 12'h004;
  localparam logic [11:0] OFS_BLACK = 12'h008;
  localparam logic [11:0] OFS_SHARP = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_WAIT_SEL = 2;
  localparam int CTRL_LIMITS_OFF = 3;
  localparam int STAT_FLAG = 0;
  localparam int STAT_FRAME = 1;
  localparam int STAT_BURST = 2;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    FMT_8 = 2'b00,
    FMT_10 = 2'b01,
    FMT_12 = 2'b10
  } pix_fmt_t;
  typedef enum logic {
    WAIT_FRAME = 1'b0,
    WAIT_BURST = 1'b1
  } wait_kind_t;
endpackage

// >>> core/pix_shift_unit.sv
// Saturating left shift and black-level offset of one pixel, combinational, no register.
`timescale 1ns/10ps
`default_nettype none
module pix_shift_unit
  import pix_pkg::*;
(
  input wire logic [pix_pkg::PIX_W-1:0] pix_in,
  input wire logic [pix_pkg::SHIFT_W-1:0] shift_in,
  input wire logic [pix_pkg::PIX_W-1:0] black_in,
  input wire pix_pkg::pix_fmt_t fmt_in,
  output logic [pix_pkg::PIX_W-1:0] pix_out
);
  function automatic logic [11:0] fmt_max(input pix_fmt_t f);
    if (f == FMT_8) begin
      fmt_max = MAX_8;
    end else if (f == FMT_10) begin
      fmt_max = MAX_10;
    end else begin
      fmt_max = MAX_12;
    end
  endfunction
  logic [PIX_W+7:0] wide;
  logic [PIX_W+7:0] sum;
  logic [PIX_W-1:0] full;
  always_comb begin
    // Shift at full depth with zero fill, then offset, then clamp.
    wide = {8'h00, pix_in} << shift_in;
    sum = wide + {8'h00, black_in};
    full = (sum > {8'h00, MAX_12}) ? MAX_12 : sum[PIX_W-1:0];
    if (fmt_in == FMT_12) begin
      pix_out = full;
    end else if (fmt_in == FMT_10) begin
      pix_out = {2'b00, full[11:2]};
    end else begin
      pix_out = {4'h0, full[11:4]};
    end
    if (pix_out > fmt_max(fmt_in)) begin
      pix_out = fmt_max(fmt_in);
    end
  end
endmodule
`default_nettype wire

// >>> core/pix_skid.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module pix_skid #(
  parameter int W = 13
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic s_valid_in,
  output logic s_ready_out,
  input wire logic [W-1:0] s_data_in,
  output logic m_valid_out,
  input wire logic m_ready_in,
  output logic [W-1:0] m_data_out
);
  typedef struct packed {
    logic [1:0] cnt;
    logic [W-1:0] d0;
    logic [W-1:0] d1;
  } skid_t;
  skid_t st_r;
  skid_t st_nxt;
  logic push;
  logic pop;
  assign s_ready_out = (st_r.cnt != 2'h2);
  assign m_valid_out = (st_r.cnt != 2'h0);
  assign m_data_out = st_r.d0;
  assign push = s_valid_in && s_ready_out;
  assign pop = m_valid_out && m_ready_in;
  always_comb begin
    st_nxt = st_r;
    if (pop) begin
      st_nxt.d0 = st_r.d1;
    end
    if (push) begin
      if (st_r.cnt == 2'h0 || (st_r.cnt == 2'h1 && pop)) begin
        st_nxt.d0 = s_data_in;
      end else begin
        st_nxt.d1 = s_data_in;
      end
    end
    st_nxt.cnt = 2'(st_r.cnt + {1'b0, push} - {1'b0, pop});
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  skid_no_over_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    st_r.cnt <= 2'h2) else $error("buffer count overflow");
endmodule
`default_nettype wire

// >>> core/pix_stage.sv
// Pixel shift and black-level stage with its AXI4-Lite register slave.
`timescale 1ns/10ps
`default_nettype none
module pix_stage
  import pix_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [pix_pkg::PIX_W-1:0] pix_data_in,
  input wire logic pix_valid_in,
  output logic pix_ready_out,
  output logic [pix_pkg::PIX_W-1:0] pix_data_out,
  output logic pix_valid_out,
  input wire logic pix_ready_in,
  input wire logic frame_trigger_waiting_in,
  input wire logic burst_trigger_waiting_in,
  output logic trigger_wait_flag_out,
  output logic [pix_pkg::SHARP_W-1:0] sharpness_out
);
  typedef struct packed {
    logic aw_have;
    logic [11:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [1:0] fmt;
    logic wait_sel;
    logic limits_off;
    logic [SHIFT_W-1:0] shift;
    logic [PIX_W-1:0] black;
    logic [SHARP_W-1:0] sharp;
    logic pv;
    logic [PIX_W-1:0] pd;
    logic [2:0] fw_sync;
    logic [2:0] bw_sync;
    logic flag;
  } state_t;
  state_t st_r;
  state_t st_nxt;
  logic [PIX_W-1:0] shifted;
  logic stall;
  logic buf_ready;
  logic [PIX_W-1:0] buf_data;
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction
  function automatic logic [5:0] clamp6(input logic [5:0] v,
                                        input logic [5:0] lim);
    clamp6 = (v > lim) ? lim : v;
  endfunction
  pix_shift_unit u_shift (
    .pix_in(st_r.pd),
    .shift_in(st_r.shift),
    .black_in(st_r.black),
    .fmt_in(pix_fmt_t'(st_r.fmt)),
    .pix_out(shifted)
  );
  assign stall = st_r.pv && !buf_ready;
  assign pix_ready_out = !stall;
  pix_skid #(.W(PIX_W)) u_buf (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .s_valid_in(st_r.pv),
    .s_ready_out(buf_ready),
    .s_data_in(shifted),
    .m_valid_out(pix_valid_out),
    .m_ready_in(pix_ready_in),
    .m_data_out(buf_data)
  );
  assign pix_data_out = buf_data;
  assign s_axi_awready = !st_r.aw_have;
  assign s_axi_wready = !st_r.w_have;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign trigger_wait_flag_out = st_r.flag;
  assign sharpness_out = st_r.sharp;
  always_comb begin
    logic [31:0] m;
    logic [5:0] slim;
    logic [2:0] hlim;
    m = '0;
    st_nxt = st_r;
    slim = st_r.limits_off ? SHARP_MAX_WIDE : SHARP_MAX_LIM;
    hlim = st_r.limits_off ? SHIFT_MAX_WIDE : SHIFT_MAX_LIM;
    if (s_axi_awvalid && !st_r.aw_have) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_have) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OK;
      if (st_r.aw_addr == OFS_CTRL) begin
        m = merge({28'h0, st_r.limits_off, st_r.wait_sel, st_r.fmt},
                  st_r.w_data, st_r.w_strb);
        if (m[CTRL_FMT_LSB +: 2] != 2'b11) begin
          st_nxt.fmt = m[CTRL_FMT_LSB +: 2];
        end
        st_nxt.wait_sel = m[CTRL_WAIT_SEL];
        st_nxt.limits_off = m[CTRL_LIMITS_OFF];
      end else if (st_r.aw_addr == OFS_SHIFT) begin
        m = merge({29'h0, st_r.shift}, st_r.w_data, st_r.w_strb);
        if (m[2:0] <= hlim) begin
          st_nxt.shift = m[2:0];
        end
      end else if (st_r.aw_addr == OFS_BLACK) begin
        m = merge({20'h0, st_r.black}, st_r.w_data, st_r.w_strb);
        st_nxt.black = m[PIX_W-1:0];
      end else if (st_r.aw_addr == OFS_SHARP) begin
        m = merge({26'h0, st_r.sharp}, st_r.w_data, st_r.w_strb);
        st_nxt.sharp = clamp6(m[5:0], slim);
      end else if (st_r.aw_addr != OFS_STATUS) begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OK;
      if (s_axi_araddr == OFS_CTRL) begin
        st_nxt.rdata = {28'h0, st_r.limits_off, st_r.wait_sel, st_r.fmt};
      end else if (s_axi_araddr == OFS_SHIFT) begin
        st_nxt.rdata = {29'h0, st_r.shift};
      end else if (s_axi_araddr == OFS_BLACK) begin
        st_nxt.rdata = {20'h0, st_r.black};
      end else if (s_axi_araddr == OFS_SHARP) begin
        st_nxt.rdata = {26'h0, st_r.sharp};
      end else if (s_axi_araddr == OFS_STATUS) begin
        st_nxt.rdata = {29'h0, st_r.bw_sync[2], st_r.fw_sync[2], st_r.flag};
      end else begin
        st_nxt.rdata = '0;
        st_nxt.rresp = RESP_SLVERR;
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (!stall) begin
      st_nxt.pv = pix_valid_in;
      st_nxt.pd = pix_data_in;
    end
    st_nxt.fw_sync = {st_r.fw_sync[1:0], frame_trigger_waiting_in};
    st_nxt.bw_sync = {st_r.bw_sync[1:0], burst_trigger_waiting_in};
    if (st_r.wait_sel == WAIT_BURST) begin
      if (st_r.bw_sync[1] == st_r.bw_sync[2]) begin
        st_nxt.flag = st_r.bw_sync[2];
      end
    end else if (st_r.fw_sync[1] == st_r.fw_sync[2]) begin
      st_nxt.flag = st_r.fw_sync[2];
    end
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
      st_r.fmt <= FMT_12;
    end else begin
      st_r <= st_nxt;
    end
  end
  sat_12bit_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.fmt == FMT_12 && st_r.pv && st_r.black == 12'h000 &&
     ({8'h00, st_r.pd} << st_r.shift) > 20'h00FFF) |-> shifted == MAX_12)
    else $error("12-bit saturation missing");
  shift_exact_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.fmt == FMT_12 && st_r.black == 12'h000 &&
     ({8'h00, st_r.pd} << st_r.shift) <= 20'h00FFF) |->
    shifted == 12'(st_r.pd << st_r.shift))
    else $error("shift result wrong");
  zero_pass_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.shift == 3'h0 && st_r.black == 12'h000 && st_r.fmt == FMT_12)
    |-> shifted == st_r.pd) else $error("zero shift not a pass");
  low_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.fmt == FMT_12 && st_r.black == 12'h000 && st_r.shift == 3'h2 &&
     shifted != MAX_12) |-> shifted[1:0] == 2'b00)
    else $error("vacated bits not zero");
  narrow_top_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.fmt == FMT_8) |-> shifted[11:8] == 4'h0)
    else $error("8-bit output too wide");
  wait_sel_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.wait_sel == WAIT_BURST && $stable(st_r.wait_sel) &&
     st_r.bw_sync[2] == st_r.bw_sync[1]) |=> st_r.flag == $past(st_r.bw_sync[2]))
    else $error("flag ignores burst wait");
  black_add_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.fmt == FMT_12 && st_r.shift == 3'h0 &&
     ({8'h00, st_r.pd} + {8'h00, st_r.black}) <= 20'h00FFF) |->
    shifted == 12'(st_r.pd + st_r.black)) else $error("offset wrong");
  sharp_lim_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !st_r.limits_off |-> st_r.sharp <= SHARP_MAX_LIM)
    else $error("sharpness beyond limit");
  latency_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (pix_valid_in && pix_ready_out) |=> st_r.pv)
    else $error("pixel lost in stage");
  cov_shift_c: cover property (@(posedge core_clk_in) st_r.pv && st_r.shift != 0);
  cov_sat_c: cover property (@(posedge core_clk_in) st_r.pv && shifted == MAX_12);
  cov_stall_c: cover property (@(posedge core_clk_in) stall);
  cov_flag_c: cover property (@(posedge core_clk_in) st_r.flag);
endmodule
`default_nettype wire

// >>> testbench/pix_sink.sv
// Pixel sink model that, on command, stalls three cycles in four and records accepted words.
`timescale 1ns/10ps
`default_nettype none
module pix_sink (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic valid_in,
  input wire logic [11:0] data_in,
  input wire logic stall_in,
  output logic ready_out
);
  logic [1:0] cnt_r;
  logic [11:0] got[$];
  assign ready_out = !stall_in || (cnt_r == 2'h0);
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      if (valid_in && ready_out) got.push_back(data_in);
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the pixel shift and black-level stage.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pix_pkg::*;
  typedef struct packed {
    logic [2:0] sh;
    logic [11:0] bl;
    logic [1:0] fmt;
    logic [11:0] px;
    logic [11:0] ex;
  } row_t;
  row_t rows [8] = '{
    '{3'h0, 12'h000, 2'h2, 12'h123, 12'h123},
    '{3'h1, 12'h000, 2'h2, 12'h123, 12'h246},
    '{3'h2, 12'h000, 2'h2, 12'h123, 12'h48C},
    '{3'h1, 12'h000, 2'h2, 12'hB17, 12'hFFF},
    '{3'h2, 12'h000, 2'h0, 12'h123, 12'h048},
    '{3'h0, 12'h000, 2'h1, 12'h123, 12'h048},
    '{3'h0, 12'h000, 2'h0, 12'hFFF, 12'h0FF},
    '{3'h1, 12'h010, 2'h2, 12'h100, 12'h210}
  };
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [11:0] pix_in = 12'h000;
  logic pvalid = 1'b0;
  logic pready;
  logic [11:0] pix_out;
  logic pvalid_out;
  logic sready;
  logic stall = 1'b0;
  logic frame_w = 1'b0;
  logic burst_w = 1'b0;
  logic flag;
  logic [5:0] sharp;
  logic [31:0] d;
  logic [1:0] r;
  int bad_count = 0;
  int samples_checked = 0;

  pix_stage dut (.core_clk_in(clk), .rst_in(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pix_data_in(pix_in), .pix_valid_in(pvalid),
    .pix_ready_out(pready), .pix_data_out(pix_out),
    .pix_valid_out(pvalid_out), .pix_ready_in(sready),
    .frame_trigger_waiting_in(frame_w), .burst_trigger_waiting_in(burst_w),
    .trigger_wait_flag_out(flag), .sharpness_out(sharp));
  pix_sink snk (.core_clk_in(clk), .rst_in(rst), .valid_in(pvalid_out),
    .data_in(pix_out), .stall_in(stall), .ready_out(sready));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    samples_checked++;
    if (got !== ex) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, ex);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ta;
    logic tw;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!(ta && tw) && (awvalid || wvalid));
    do @(negedge clk); while (!bvalid);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic put(input logic [11:0] p, input logic last);
    pix_in <= p;
    pvalid <= 1'b1;
    do @(negedge clk); while (!pready);
    @(posedge clk);
    if (last) pvalid <= 1'b0;
  endtask

  task automatic take(input logic [11:0] ex);
    logic [11:0] g;
    g = 12'hXXX;
    repeat (60) if (snk.got.size() == 0) @(posedge clk);
    if (snk.got.size() != 0) g = snk.got.pop_front();
    chk({20'h0, g}, {20'h0, ex});
  endtask

  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_SHIFT);
    chk(d, 32'h0);
    foreach (rows[i]) begin
      wr(OFS_SHIFT, {29'h0, rows[i].sh});
      wr(OFS_BLACK, {20'h0, rows[i].bl});
      wr(OFS_CTRL, {30'h0, rows[i].fmt});
      put(rows[i].px, 1'b1);
      take(rows[i].ex);
    end
    wr(12'h020, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(OFS_SHIFT, 32'h5);
    rd(OFS_SHIFT);
    chk(d, 32'h1);
    wr(OFS_SHARP, 32'h9);
    chk({26'h0, sharp}, 32'h3);
    wr(OFS_CTRL, 32'hA);
    wr(OFS_SHARP, 32'h9);
    chk({26'h0, sharp}, 32'h9);
    wr(OFS_SHIFT, 32'h7);
    rd(OFS_SHIFT);
    chk(d, 32'h7);
    put(12'h001, 1'b1);
    take(12'h090);
    wr(OFS_SHIFT, 32'h1);
    stall <= 1'b1;
    for (int i = 0; i < 6; i++) put(12'h100 + 12'(i), i == 5);
    stall <= 1'b0;
    for (int i = 0; i < 6; i++) take(12'h210 + 12'(2 * i));
    frame_w <= 1'b1;
    repeat (8) @(posedge clk);
    chk({31'h0, flag}, 32'h1);
    wr(OFS_CTRL, 32'hE);
    repeat (8) @(posedge clk);
    chk({31'h0, flag}, 32'h0);
    burst_w <= 1'b1;
    repeat (8) @(posedge clk);
    rd(OFS_STATUS);
    chk({29'h0, d[2:0]}, 32'h7);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_SHIFT);
    chk(d, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
